// file: logic/output_sync_timing_monitor_regs.vh
// Register indices, reset values and codes of the output sync timing monitor.
// Assumes a 32-bit Avalon-MM slave; the byte address of a register is four times its index.
`ifndef OUTPUT_SYNC_TIMING_MONITOR_REGS_VH
`define OUTPUT_SYNC_TIMING_MONITOR_REGS_VH

// Register indices (byte address = index * 4)
`define IDX_SYNC_MODE        6'h01
`define IDX_CYCLE_TIME       6'h02
`define IDX_SHIFT_TIME       6'h03
`define IDX_MODES_SUPPORTED  6'h04
`define IDX_MIN_CYCLE        6'h05
`define IDX_CALC_COPY        6'h06
`define IDX_MIN_DELAY        6'h07
`define IDX_COMMAND          6'h08
`define IDX_MAX_DELAY        6'h09
`define IDX_MISSED_COUNT     6'h0B
`define IDX_OVERRUN_COUNT    6'h0C
`define IDX_SHORT_COUNT      6'h0D
`define IDX_INPUT_SHIFT      6'h13
`define IDX_LATE_FLAG        6'h20

// Reset values
`define RST_SYNC_MODE        16'h0001
`define RST_CYCLE_TIME       32'h000F4240
`define RST_SHIFT_TIME       32'h00000000
`define RST_MODES_SUPPORTED  16'hC007
`define RST_MIN_CYCLE        32'h0003D090
`define RST_TIME_ZERO        32'h00000000
`define RST_COMMAND          16'h0000
`define RST_COUNT            16'h0000

// Supported-modes field positions
`define MODES_FREE_RUN_BIT   0
`define MODES_SM2_BIT        1
`define MODES_DC_LSB         2
`define MODES_SHIFT_LSB      4
`define MODES_DYNAMIC_BIT    14
`define MODES_RESERVED_BIT   15

// Output sync mode codes
`define MODE_FREE_RUN        16'h0000
`define MODE_SM2             16'h0001
`define MODE_SYNC0           16'h0002
`define MODE_SYNC1           16'h0003

// Measurement command codes
`define CMD_STOP             16'h0000
`define CMD_START            16'h0001

// Event pin positions in the synchroniser vector
`define EV_SYNC0             0
`define EV_SYNC1             1
`define EV_SM2               2
`define EV_OUT_DRIVEN        3
`define EV_CALC_DONE         4
`define EV_INPUT_LATCH       5
`define EV_OP_STATE          6
`define EV_COUNT             7

`endif

// file: logic/output_sync_timing_monitor.v
// Output-side synchronisation timing monitor: timing entries, measurement and error counters.
// Assumes one 20 MHz clock, an Avalon-MM master on the same clock, and event pins
// from outside the clock domain that each pulse for at least two clock periods.
//
// Chosen here: the Avalon-MM register port.

`timescale 1ns/10ps
`default_nettype none

`include "output_sync_timing_monitor_regs.vh"

module output_sync_timing_monitor #(
   parameter [31:0] CLK_PERIOD_NS = 32'h00000032
) (
   // Clock, reset and clock enable
   input  wire        I_CLK,
   input  wire        I_RESET_N,
   input  wire        I_CLK_EN,
   // Avalon-MM slave
   input  wire [7:0]  I_ADDRESS,
   input  wire        I_READ,
   input  wire        I_WRITE,
   input  wire [31:0] I_WRITEDATA,
   input  wire [3:0]  I_BYTEENABLE,
   output wire [31:0] O_READDATA,
   output wire        O_WAITREQUEST,
   // Event pins, asynchronous to I_CLK
   input  wire        I_SYNC0,
   input  wire        I_SYNC1,
   input  wire        I_SM2_EVENT,
   input  wire        I_OUTPUT_DRIVEN,
   input  wire        I_CALC_DONE,
   input  wire        I_INPUT_LATCH,
   input  wire        I_OP_STATE,
   // Status
   output wire        O_MEASURING,
   output wire        O_LATE_OUTPUT
);

   // Byte-lane merge of a write into a 32-bit register
   function [31:0] merge32;
      input [31:0] old_value;
      input [31:0] new_value;
      input [3:0]  lanes;
      integer      k;
      begin
         merge32 = old_value;
         for (k = 0; k < 4; k = k + 1) begin
            if (lanes[k]) begin
               merge32[k*8 +: 8] = new_value[k*8 +: 8];
            end
         end
      end
   endfunction

   // Saturating increment, held at all ones
   function [15:0] sat_inc;
      input [15:0] value;
      begin
         sat_inc = (value == 16'hFFFF) ? value : value + 16'h0001;
      end
   endfunction

   wire [`EV_COUNT-1:0] pins_raw;
   reg  [`EV_COUNT-1:0] meta_reg;
   reg  [`EV_COUNT-1:0] sync_reg;
   reg  [`EV_COUNT-1:0] prev_reg;
   wire [`EV_COUNT-1:0] rise;

   reg         ack_reg;
   reg  [31:0] readdata_reg;
   reg  [31:0] readdata_next;
   reg  [15:0] sync_mode_reg;
   reg  [31:0] cycle_time_reg;
   reg  [15:0] command_reg;
   reg  [31:0] shift_time_reg;
   reg  [31:0] min_cycle_reg;
   reg  [31:0] calc_copy_reg;
   reg  [31:0] min_delay_reg;
   reg  [31:0] max_delay_reg;
   reg  [31:0] input_shift_reg;
   reg  [15:0] missed_reg;
   reg  [15:0] overrun_reg;
   reg  [15:0] short_reg;
   reg         late_reg;

   reg  [31:0] now_reg;
   reg  [31:0] sync0_t_reg;
   reg  [31:0] sync1_t_reg;
   reg  [31:0] start_t_reg;
   reg         started_reg;
   reg         busy_reg;
   reg         sm_seen_reg;
   reg         sync1_seen_reg;

   wire [5:0]  index;
   wire        wr_fire;
   wire        start_cmd;
   wire        measuring;
   wire        dc_mode;
   wire        op_state;
   wire        cycle_start;
   wire [31:0] since_sync0;
   wire [31:0] since_sync1;
   wire [31:0] since_start;
   wire [15:0] modes_word;
   wire [31:0] mode_merged;
   wire [31:0] cmd_merged;

   assign pins_raw = {I_OP_STATE, I_INPUT_LATCH, I_CALC_DONE, I_OUTPUT_DRIVEN,
                      I_SM2_EVENT, I_SYNC1, I_SYNC0};

   // Two-flop synchroniser per pin, then an edge detector on the second stage
   genvar g;
   generate
      for (g = 0; g < `EV_COUNT; g = g + 1) begin : g_pin
         always @(posedge I_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               meta_reg[g] <= 1'b0;
               sync_reg[g] <= 1'b0;
               prev_reg[g] <= 1'b0;
            end else if (I_CLK_EN) begin
               meta_reg[g] <= pins_raw[g];
               sync_reg[g] <= meta_reg[g];
               prev_reg[g] <= sync_reg[g];
            end
         end
         assign rise[g] = sync_reg[g] & ~prev_reg[g];
      end
   endgenerate

   // Mode decode
   assign dc_mode  = (sync_mode_reg == `MODE_SYNC0) || (sync_mode_reg == `MODE_SYNC1);
   assign op_state = sync_reg[`EV_OP_STATE];
   // A cycle opens on SYNC0 in DC mode and on the SM2 event otherwise
   assign cycle_start = dc_mode ? rise[`EV_SYNC0] : rise[`EV_SM2];
   assign since_sync0 = now_reg - sync0_t_reg;
   assign since_sync1 = now_reg - sync1_t_reg;
   assign since_start = now_reg - start_t_reg;

   // Fixed capability word; bits 4-5 stay 00 since outputs are never shifted by SYNC1 here
   assign modes_word = (16'h0001 << `MODES_FREE_RUN_BIT)
                     | (16'h0001 << `MODES_SM2_BIT)
                     | (16'h0001 << `MODES_DC_LSB)
                     | (16'h0001 << `MODES_RESERVED_BIT)
                     | (16'h0001 << `MODES_DYNAMIC_BIT);

   // Bus decode: waitrequest drops one cycle after a request, and stays up while frozen
   assign index         = I_ADDRESS[7:2];
   assign O_WAITREQUEST = (I_READ | I_WRITE) & ~(ack_reg & I_CLK_EN);
   assign wr_fire       = I_CLK_EN & I_WRITE & ack_reg;
   assign start_cmd     = wr_fire && (index == `IDX_COMMAND) && I_BYTEENABLE[0]
                          && (I_WRITEDATA[15:0] == `CMD_START);
   assign measuring     = (command_reg == `CMD_START);

   assign O_READDATA    = readdata_reg;
   assign O_MEASURING   = measuring;
   assign O_LATE_OUTPUT = late_reg;

   // Byte-lane merges of the 16-bit writable registers; only lanes 0 and 1 reach them
   assign mode_merged   = merge32({16'h0000, sync_mode_reg}, I_WRITEDATA,
                                  {2'b00, I_BYTEENABLE[1:0]});
   assign cmd_merged    = merge32({16'h0000, command_reg}, I_WRITEDATA,
                                  {2'b00, I_BYTEENABLE[1:0]});

   // Read mux; unmapped indices read as zero
   always @* begin
      readdata_next = 32'h00000000;
      case (index)
         `IDX_SYNC_MODE:       readdata_next[15:0] = sync_mode_reg;
         `IDX_CYCLE_TIME:      readdata_next = cycle_time_reg;
         `IDX_SHIFT_TIME:      readdata_next = shift_time_reg;
         `IDX_MODES_SUPPORTED: readdata_next[15:0] = modes_word;
         `IDX_MIN_CYCLE:       readdata_next = min_cycle_reg;
         `IDX_CALC_COPY:       readdata_next = calc_copy_reg;
         `IDX_MIN_DELAY:       readdata_next = min_delay_reg;
         `IDX_COMMAND:         readdata_next[15:0] = command_reg;
         `IDX_MAX_DELAY:       readdata_next = max_delay_reg;
         `IDX_MISSED_COUNT:    readdata_next[15:0] = missed_reg;
         `IDX_OVERRUN_COUNT:   readdata_next[15:0] = overrun_reg;
         `IDX_SHORT_COUNT:     readdata_next[15:0] = short_reg;
         `IDX_INPUT_SHIFT:     readdata_next = input_shift_reg;
         `IDX_LATE_FLAG:       readdata_next[0] = late_reg;
         default:              readdata_next = 32'h00000000;
      endcase
   end

   // Bus handshake and writable registers
   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ack_reg        <= 1'b0;
         readdata_reg   <= 32'h00000000;
         sync_mode_reg  <= `RST_SYNC_MODE;
         cycle_time_reg <= `RST_CYCLE_TIME;
         command_reg    <= `RST_COMMAND;
      end else if (I_CLK_EN) begin
         ack_reg <= (I_READ | I_WRITE) & ~ack_reg;
         if (I_READ && !ack_reg) begin
            readdata_reg <= readdata_next;
         end
         if (wr_fire) begin
            case (index)
               `IDX_SYNC_MODE: begin
                  sync_mode_reg <= mode_merged[15:0];
               end
               `IDX_CYCLE_TIME: begin
                  cycle_time_reg <= merge32(cycle_time_reg, I_WRITEDATA, I_BYTEENABLE);
               end
               `IDX_COMMAND: begin
                  command_reg <= cmd_merged[15:0];
               end
               default: begin
                  command_reg <= command_reg;
               end
            endcase
         end
      end
   end

   // Local time base in ns and cycle bookkeeping
   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         now_reg        <= 32'h00000000;
         sync0_t_reg    <= 32'h00000000;
         sync1_t_reg    <= 32'h00000000;
         start_t_reg    <= 32'h00000000;
         started_reg    <= 1'b0;
         busy_reg       <= 1'b0;
         sm_seen_reg    <= 1'b0;
         sync1_seen_reg <= 1'b0;
      end else if (I_CLK_EN) begin
         now_reg <= now_reg + CLK_PERIOD_NS;
         if (rise[`EV_SYNC0]) begin
            sync0_t_reg    <= now_reg;
            sync1_seen_reg <= 1'b0;
         end
         if (rise[`EV_SYNC1]) begin
            sync1_t_reg    <= now_reg;
            sync1_seen_reg <= 1'b1;
         end
         // Outputs driven closes the cycle; a new start reopens it
         if (cycle_start) begin
            start_t_reg <= now_reg;
            started_reg <= 1'b1;
            busy_reg    <= 1'b1;
         end else if (rise[`EV_OUT_DRIVEN]) begin
            busy_reg <= 1'b0;
         end
         // SM2 seen since the last SYNC0; an event in the same cycle as SYNC0 counts
         if (rise[`EV_SM2]) begin
            sm_seen_reg <= 1'b1;
         end else if (rise[`EV_SYNC0]) begin
            sm_seen_reg <= 1'b0;
         end
      end
   end

   // Measured timing entries; a start command wipes them before new maxima build up
   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         shift_time_reg  <= `RST_SHIFT_TIME;
         min_cycle_reg   <= `RST_MIN_CYCLE;
         calc_copy_reg   <= `RST_TIME_ZERO;
         min_delay_reg   <= `RST_TIME_ZERO;
         max_delay_reg   <= `RST_TIME_ZERO;
         input_shift_reg <= `RST_SHIFT_TIME;
      end else if (I_CLK_EN) begin
         if (start_cmd) begin
            shift_time_reg  <= `RST_TIME_ZERO;
            min_cycle_reg   <= `RST_TIME_ZERO;
            calc_copy_reg   <= `RST_TIME_ZERO;
            min_delay_reg   <= `RST_TIME_ZERO;
            max_delay_reg   <= `RST_TIME_ZERO;
            input_shift_reg <= `RST_TIME_ZERO;
         end else if (measuring) begin
            if (rise[`EV_OUT_DRIVEN] && dc_mode && since_sync0 > shift_time_reg) begin
               shift_time_reg <= since_sync0;
            end
            if (cycle_start && started_reg && since_start > min_cycle_reg) begin
               min_cycle_reg <= since_start;
            end
            if (rise[`EV_CALC_DONE] && started_reg && since_start > calc_copy_reg) begin
               calc_copy_reg <= since_start;
            end
            // Both delay entries keep the largest SYNC1-to-output time
            if (rise[`EV_OUT_DRIVEN] && dc_mode && sync1_seen_reg) begin
               if (since_sync1 > min_delay_reg) begin
                  min_delay_reg <= since_sync1;
               end
               if (since_sync1 > max_delay_reg) begin
                  max_delay_reg <= since_sync1;
               end
            end
            if (rise[`EV_INPUT_LATCH] && dc_mode && since_sync0 > input_shift_reg) begin
               input_shift_reg <= since_sync0;
            end
         end
      end
   end

   // Diagnostic counters and late-output flag
   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         missed_reg  <= `RST_COUNT;
         overrun_reg <= `RST_COUNT;
         short_reg   <= `RST_COUNT;
         late_reg    <= 1'b0;
      end else if (I_CLK_EN) begin
         // A SYNC0 with no SM2 event since the previous one is a missed event
         if (rise[`EV_SYNC0] && op_state && dc_mode && started_reg
             && !sm_seen_reg && !rise[`EV_SM2]) begin
            missed_reg <= sat_inc(missed_reg);
         end
         // Overrun: previous outputs still pending, or the cycle came early
         if (cycle_start && op_state && started_reg
             && (busy_reg || since_start < min_cycle_reg)) begin
            overrun_reg <= sat_inc(overrun_reg);
         end
         if (rise[`EV_SYNC1] && dc_mode && since_sync0 < calc_copy_reg) begin
            short_reg <= sat_inc(short_reg);
         end
         // In DC mode the flag reflects only the cycle just closed; otherwise it is held low
         if (!dc_mode) begin
            late_reg <= 1'b0;
         end else if (cycle_start) begin
            late_reg <= started_reg & busy_reg;
         end
      end
   end

endmodule // output_sync_timing_monitor

`default_nettype wire

// file: testbench/output_sync_timing_monitor_props.sv
// Checker on the monitor's bus and status ports.
// Assumes event pins pulse only while I_CLK_EN is high.
`timescale 1ns/10ps
`default_nettype none
module output_sync_timing_monitor_props (
   // Clock and reset
   input wire        I_CLK,
   input wire        I_RESET_N,
   input wire        I_CLK_EN,
   // Bus
   input wire [7:0]  I_ADDRESS,
   input wire        I_READ,
   input wire        I_WRITE,
   input wire [31:0] I_WRITEDATA,
   input wire [3:0]  I_BYTEENABLE,
   input wire [31:0] O_READDATA,
   input wire        O_WAITREQUEST,
   // Events and status
   input wire        I_SYNC0,
   input wire        O_MEASURING,
   input wire        O_LATE_OUTPUT
);
   // Completed accesses; a stalled clock enable takes nothing
   wire cmd_any  = I_WRITE && !O_WAITREQUEST && I_CLK_EN && I_ADDRESS[7:2] == 6'h08;
   wire cmd_full = cmd_any && I_BYTEENABLE[1:0] == 2'b11;
   wire rd_done  = I_READ && !O_WAITREQUEST && I_CLK_EN;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   AST_MEAS_START: assert property (
      cmd_full && I_WRITEDATA[15:0] == 16'h0001 |=> O_MEASURING)
      else $error("measuring did not start");
   AST_MEAS_STOP: assert property (
      cmd_full && I_WRITEDATA[15:0] == 16'h0000 |=> !O_MEASURING)
      else $error("measuring did not stop");
   AST_MEAS_HOLD: assert property (
      !cmd_any |=> $stable(O_MEASURING))
      else $error("measuring changed without a command write");
   AST_WAIT_ONE: assert property (
      $rose(I_READ) && I_CLK_EN |-> O_WAITREQUEST ##1 !O_WAITREQUEST)
      else $error("read did not take exactly one wait cycle");
   AST_IDLE_NO_WAIT: assert property (
      !I_READ && !I_WRITE |-> !O_WAITREQUEST)
      else $error("waitrequest without a request");
   AST_MODES_WORD: assert property (
      rd_done && I_ADDRESS[7:2] == 6'h04 |-> O_READDATA == 32'h0000C007)
      else $error("supported modes word wrong");
   AST_UNMAPPED_ZERO: assert property (
      rd_done && I_ADDRESS[7:2] == 6'h3F |-> O_READDATA == 32'h00000000)
      else $error("unmapped read not zero");
   AST_LATE_CAUSE: assert property (
      $rose(O_LATE_OUTPUT) |-> $past(I_SYNC0, 3) && !$past(I_SYNC0, 4))
      else $error("late flag rose away from a cycle start");
endmodule // output_sync_timing_monitor_props
`default_nettype wire

// file: testbench/sync_event_source.sv
// Event source model: the far side's SYNC0/SYNC1, SM2 and local timing pulses.
// Assumes the caller paces cycles; pins idle low and pulse high for two clocks.
`timescale 1ns/10ps
`default_nettype none
module sync_event_source (
   // Clock
   input  wire  i_clk,
   // Event pins
   output logic o_sync0,
   output logic o_sync1,
   output logic o_sm2,
   output logic o_out,
   output logic o_calc,
   output logic o_latch
);
   // Idle at start so the monitor sees no spurious edge
   initial {o_sync0, o_sync1, o_sm2, o_out, o_calc, o_latch} = 6'h00;
   // High while a pulse of delay d stands; zero leaves the pulse out
   function automatic logic hit(input int t, input int d);
      return d != 0 && t >= d && t < d + 2;
   endfunction
   // SYNC0 opens every cycle, so the period is the cycle time
   task automatic run_cycle(input int period, c, s1, od, sm, lt);
      for (int t = 0; t < period; t++) begin
         @(posedge i_clk);
         o_sync0 <= t < 2;
         o_sync1 <= hit(t, s1);
         o_calc  <= hit(t, c);
         o_out   <= hit(t, od);
         o_sm2   <= hit(t, sm);
         o_latch <= hit(t, lt);
      end
   endtask
endmodule // sync_event_source
`default_nettype wire

// file: testbench/tb_output_sync_timing_monitor.sv
// Bench for the output sync timing monitor: registers, measurement, counters.
// Assumes the event source model paces SYNC0 cycles of 40 clocks.
`timescale 1ns/10ps
`default_nettype none
module tb_output_sync_timing_monitor;
   localparam int NS = 50;
   logic        clk, rst_n, ce, rd, wr, op;
   logic [7:0]  addr;
   logic [31:0] wdata, rv;
   logic [3:0]  be;
   wire  [31:0] rdata;
   wire         waitreq, meas, late, s0, s1p, sm2, outd, calc, latch;
   int          n_mismatch, checked, m_sh, m_dl, m_cc, m_in, n_ms, n_ov, n_sh;
   logic [5:0]  t_idx [13] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
      6'h09, 6'h0B, 6'h0C, 6'h0D, 6'h20};
   logic [31:0] t_rst [13] = '{0: 32'h1, 1: 32'hF4240, 3: 32'hC007, 4: 32'h3D090,
      default: 32'h0};
   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   output_sync_timing_monitor i_dut (
      .I_CLK(clk), .I_RESET_N(rst_n), .I_CLK_EN(ce), .I_ADDRESS(addr), .I_READ(rd),
      .I_WRITE(wr), .I_WRITEDATA(wdata), .I_BYTEENABLE(be), .O_READDATA(rdata),
      .O_WAITREQUEST(waitreq), .I_SYNC0(s0), .I_SYNC1(s1p), .I_SM2_EVENT(sm2),
      .I_OUTPUT_DRIVEN(outd), .I_CALC_DONE(calc), .I_INPUT_LATCH(latch), .I_OP_STATE(op),
      .O_MEASURING(meas), .O_LATE_OUTPUT(late));
   sync_event_source i_src (.i_clk(clk), .o_sync0(s0), .o_sync1(s1p), .o_sm2(sm2),
      .o_out(outd), .o_calc(calc), .o_latch(latch));
   // Running maximum for measured expectations
   function automatic int mx(input int a, input int b);
      return a > b ? a : b;
   endfunction
   // Counts and verdict; the only way the run ends
   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Compare seen against expected, four-state
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One Avalon transfer; the request holds until waitrequest is low at an edge
   task automatic bus(input logic we, input logic [5:0] idx, input logic [31:0] wd,
                      input logic [3:0] ben);
      int   n;
      logic w;
      @(posedge clk);
      {rd, wr, addr, wdata, be} <= {!we, we, idx, 2'b00, wd, ben};
      n = 0;
      // Settled values just ahead of a rising edge are what that edge samples
      do begin
         @(negedge clk);
         w = waitreq;
         rv = rdata;
         @(posedge clk);
         n++;
      end while (w !== 1'b0 && n < 20);
      if (w !== 1'b0) begin
         n_mismatch++;
         conclude();
      end else begin
         {rd, wr} <= 2'b00;
      end
   endtask
   // Read one register and compare it
   task automatic rdchk(input string what, input logic [5:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0, 4'hF);
      chk(what, rv, exp);
   endtask
   // Main sequence
   initial begin
      int k, c, s1, od, lt, nsm, nout, shrt, psm, pout;
      {rst_n, ce, rd, wr, op, addr, wdata, be} = {5'b01000, 8'h00, 32'h0, 4'hF};
      void'($urandom(71));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values; writes to read-only and unmapped places change nothing
      for (int i = 0; i < 13; i++) begin
         rdchk("reset", t_idx[i], t_rst[i]);
         if (i > 1 && i != 7) begin
            bus(1'b1, t_idx[i], $urandom, 4'hF);
            rdchk("read only", t_idx[i], t_rst[i]);
         end
      end
      bus(1'b1, 6'h3F, $urandom, 4'hF);
      rdchk("unmapped", 6'h3F, 32'h0);
      // Every mode code, ending in a DC mode, and a random cycle time
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, 6'h01, m, 4'hF);
         rdchk("sync mode", 6'h01, m);
      end
      k = $urandom;
      bus(1'b1, 6'h02, k, 4'hF);
      rdchk("cycle time", 6'h02, k);
      $display("test registers done");
      // Command: low lanes off do nothing, then start and stop
      bus(1'b1, 6'h08, 32'h1, 4'hC);
      @(negedge clk);
      chk("measuring", meas, 1'b0);
      bus(1'b1, 6'h08, 32'h1, 4'hF);
      @(negedge clk);
      chk("measuring", meas, 1'b1);
      rdchk("command", 6'h08, 32'h1);
      bus(1'b1, 6'h08, 32'h0, 4'hF);
      @(negedge clk);
      chk("measuring", meas, 1'b0);
      // Start again while the clock enable freezes the bus just after the request is seen
      fork
         bus(1'b1, 6'h08, 32'h1, 4'hF);
         begin
            repeat (2) @(posedge clk);
            ce <= 1'b0;
            repeat (2) @(posedge clk);
            ce <= 1'b1;
         end
      join
      @(negedge clk);
      chk("frozen start", meas, 1'b1);
      // Random cycles, outputs in time; the entries keep the largest values
      for (k = 0; k < 6; k++) begin
         c = $urandom_range(5, 2);
         s1 = $urandom_range(11, 8);
         od = s1 + $urandom_range(5, 2);
         lt = $urandom_range(12, 3);
         m_sh = mx(m_sh, od * NS);
         m_dl = mx(m_dl, (od - s1) * NS);
         m_cc = mx(m_cc, c * NS);
         m_in = mx(m_in, lt * NS);
         i_src.run_cycle(40, c, s1, od, 20, lt);
      end
      bus(1'b1, 6'h08, 32'h0, 4'hF);
      rdchk("shift", 6'h03, m_sh);
      rdchk("min cycle", 6'h05, 40 * NS);
      rdchk("calc copy", 6'h06, m_cc);
      rdchk("min delay", 6'h07, m_dl);
      rdchk("max delay", 6'h09, m_dl);
      rdchk("input shift", 6'h13, m_in);
      $display("test measurement done");
      // Operational cycles with random faults; the last one is clean
      op <= 1'b1;
      {psm, pout} = 0;
      for (k = 0; k < 9; k++) begin
         nsm = k == 4 || (k < 8 && $urandom_range(2) == 0);
         nout = k == 2 || (k < 8 && $urandom_range(2) == 0);
         shrt = k == 5 || (k < 8 && $urandom_range(2) == 0);
         s1 = shrt ? 1 : 12;
         n_ms += psm;
         n_ov += pout;
         n_sh += shrt;
         i_src.run_cycle(40, 3, s1, nout ? 0 : s1 + 3, nsm ? 0 : 20, 5);
         @(negedge clk);
         chk("late flag", late, pout);
         psm = nsm;
         pout = nout;
      end
      rdchk("missed", 6'h0B, n_ms);
      rdchk("overrun", 6'h0C, n_ov);
      rdchk("short", 6'h0D, n_sh);
      // SM2 mode: SM2 opens the cycle, so only the overrun counts; DC-only parts stay quiet
      bus(1'b1, 6'h01, 32'h1, 4'hF);
      repeat (2) i_src.run_cycle(40, 3, 1, 0, 20, 5);
      @(negedge clk);
      chk("late flag", late, 1'b0);
      rdchk("missed", 6'h0B, n_ms);
      rdchk("overrun", 6'h0C, n_ov + 1);
      rdchk("short", 6'h0D, n_sh);
      $display("test counters done");
      // A fresh start clears what the last run measured
      bus(1'b1, 6'h08, 32'h1, 4'hF);
      rdchk("shift cleared", 6'h03, 32'h0);
      rdchk("cycle cleared", 6'h05, 32'h0);
      rdchk("delay cleared", 6'h09, 32'h0);
      $display("test restart done");
      conclude();
   end
   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      conclude();
   end
endmodule // tb_output_sync_timing_monitor
bind output_sync_timing_monitor output_sync_timing_monitor_props i_props (
   .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_CLK_EN(I_CLK_EN), .I_ADDRESS(I_ADDRESS),
   .I_READ(I_READ), .I_WRITE(I_WRITE), .I_WRITEDATA(I_WRITEDATA), .I_SYNC0(I_SYNC0),
   .I_BYTEENABLE(I_BYTEENABLE), .O_READDATA(O_READDATA), .O_WAITREQUEST(O_WAITREQUEST),
   .O_MEASURING(O_MEASURING), .O_LATE_OUTPUT(O_LATE_OUTPUT));
`default_nettype wire
